// ### rtl/wtc_pkg.sv
// Shared constants and carrier types for the write-through cache directory
package wtc_pkg;

  // Register map, byte addresses
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] TMASK_OFF  = 8'h04;
  localparam logic [7:0] STAT_OFF   = 8'h08;
  localparam logic [7:0] HITS_OFF   = 8'h0c;
  localparam logic [7:0] MISS_OFF   = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_BLK4_BIT = 1;
  localparam int unsigned CTRL_ILV_LSB  = 2;
  localparam int unsigned CTRL_UNIT_LSB = 4;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [19:0] TMASK_RST     = 20'hf_ffff;

  // Status register fields
  localparam int unsigned STAT_EN_BIT   = 0;
  localparam int unsigned STAT_TGL_BIT  = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;

  // Directory geometry
  localparam int unsigned WAYS      = 2;
  localparam int unsigned SETS      = 64;
  localparam int unsigned SET_W     = 6;
  localparam int unsigned LINES     = 8;
  localparam int unsigned TAG_W     = 20;
  localparam int unsigned TAG_LSB   = 12;
  localparam int unsigned LINE_LSB  = 4;
  localparam int unsigned BLK8_SHIFT = 7;
  localparam int unsigned BLK4_SHIFT = 6;

  // Interleave codes
  localparam logic [1:0] ILV_ONE  = 2'h0;
  localparam logic [1:0] ILV_TWO  = 2'h1;
  localparam logic [1:0] ILV_FOUR = 2'h2;

  typedef enum logic [0:0] {
    WTC_IDLE = 1'b0,
    WTC_MEM  = 1'b1
  } wtc_state_t;

  // Processor request on the local bus
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        write;
    logic        cacheable;
    logic        recog;
    logic        locked;
  } wtc_req_t;

  // Completion back to the processor plus SRAM strobes
  typedef struct packed {
    logic done;
    logic hit;
    logic way;
    logic bad_access_flag;
    logic cache_read;
    logic cache_write;
  } wtc_resp_t;

  // Request toward the system bus
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        write;
    logic        line16;
  } wtc_sbreq_t;

  // Reply from the system bus
  typedef struct packed {
    logic done;
    logic bad;
  } wtc_sbrep_t;

  // Observed system-bus write
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        from_self;
    logic        cacheable;
  } wtc_snoop_t;

endpackage

// ### rtl/wtc_cache_dir.sv
// Write-through cache directory with snoop invalidation and AHB-Lite control
// How it works
// - Hit needs tag match in a way and the requested line valid bit set.
// - Cacheable read miss fetches from system memory and updates the cache.
// - Write miss leaves cache untouched and forwards write over the system bus.
// - Transfer size and fetch versus data access never change cache behaviour.
// - Line of sixteen bytes is the transfer and hit or miss unit.
// - Address block covers eight or four lines, 128 or 64 bytes, by configuration.
// - Two-way set associative, 64 sets, set index decoded from address.
// - Both ways of the selected set are compared in parallel.
// - Tag is address bits 31..12, maskable by configuration.
// - Eight line-valid bits per entry, unused ones masked by configuration.
// - Cleared tag-valid bit makes the entry ignored and never hit.
// - Single toggle flipping on each cacheable access picks the replacement way.
// - Toggle reset by unit reset and by clearing cache enable; first goes way 0.
// - Write miss never allocates nor fetches surrounding data.
// - Write hit updates cache and also writes main memory.
// - Foreign or own non-cacheable system-bus writes invalidate a hit line.
// - Snoop invalidation always covers the whole sixteen-byte line.
// - Configuration can shrink effective directory; storage stays full size.
// - Number of sharing units equals interleave factor one, two or four.
// - Each unit addresses sixteen kilobytes of cache data.
// - Cacheable needs recognizer match, cacheable line high, and no locked access.
// - Read miss issues aligned sixteen-byte request, fill starts at word zero.
// - Bad-access reply on a fill invalidates whole directory and flags processor.
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module wtc_cache_dir (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire wtc_pkg::wtc_req_t   req_i,
  output logic                   req_ready_o,
  output wtc_pkg::wtc_resp_t       resp_o,
  output wtc_pkg::wtc_sbreq_t      sbreq_o,
  input  wire wtc_pkg::wtc_sbrep_t sbrep_i,
  input  wire wtc_pkg::wtc_snoop_t snoop_i,
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic [31:0]            hrdata_o,
  output logic                   hreadyout_o,
  output logic                   hresp_o
);

  // Configuration
  logic                       en_ff;
  logic                       blk4_ff;
  logic [1:0]                 ilv_ff;
  logic [1:0]                 unit_ff;
  logic [wtc_pkg::TAG_W-1:0]  tmask_ff;
  logic [1:0]                 ibits;

  // Directory storage, always full size
  logic [wtc_pkg::TAG_W-1:0]  tag_ff [wtc_pkg::WAYS][wtc_pkg::SETS];
  logic [wtc_pkg::LINES-1:0]  lv_ff  [wtc_pkg::WAYS][wtc_pkg::SETS];
  logic [wtc_pkg::SETS-1:0]   tv_ff  [wtc_pkg::WAYS];

  // Control state
  wtc_pkg::wtc_state_t        state_ff;
  logic                       toggle_ff;
  logic [31:0]                p_addr_ff;
  logic                       p_fill_ff;
  logic                       p_whit_ff;
  logic                       p_way_ff;
  logic                       p_tagm_ff;
  logic [31:0]                hits_ff;
  logic [31:0]                miss_ff;

  // AHB-Lite data phase
  logic                       aw_pend_ff;
  logic [7:0]                 aw_addr_ff;

  // Lookup signals
  logic [wtc_pkg::SET_W-1:0]  rq_set;
  logic [2:0]                 rq_line;
  logic [wtc_pkg::TAG_W-1:0]  rq_tag;
  logic [wtc_pkg::WAYS-1:0]   rq_tagm;
  logic [wtc_pkg::WAYS-1:0]   rq_hitv;
  logic                       rq_hit;
  logic                       rq_mine;
  logic [wtc_pkg::SET_W-1:0]  sn_set;
  logic [2:0]                 sn_line;
  logic [wtc_pkg::TAG_W-1:0]  sn_tag;
  logic [wtc_pkg::WAYS-1:0]   sn_tagm;
  logic [wtc_pkg::WAYS-1:0]   sn_hitv;
  logic                       sn_clr;
  logic                       sn_way;
  logic                       accept;
  logic                       serve;
  logic                       cach;
  logic                       fill_ok;
  logic                       fill_bad;
  logic [wtc_pkg::SET_W-1:0]  p_set;
  logic [2:0]                 p_line;
  logic                       ahb_addr_ph;
  logic [31:0]                rd_val;

  function automatic logic [31:0] blk_shift(input logic [31:0] a, input logic b4);
    return b4 ? (a >> wtc_pkg::BLK4_SHIFT) : (a >> wtc_pkg::BLK8_SHIFT);
  endfunction

  function automatic logic [wtc_pkg::SET_W-1:0] set_of(input logic [31:0] a,
                                                       input logic b4,
                                                       input logic [1:0] ib);
    logic [31:0] s;
    s = blk_shift(a, b4) >> ib;
    return s[wtc_pkg::SET_W-1:0];
  endfunction

  // Unused line bits stay zero in 64-byte blocks
  function automatic logic [2:0] line_of(input logic [31:0] a, input logic b4);
    return b4 ? {1'b0, a[wtc_pkg::LINE_LSB+1:wtc_pkg::LINE_LSB]}
              : a[wtc_pkg::LINE_LSB+2:wtc_pkg::LINE_LSB];
  endfunction

  // Interleave slot owned by this unit
  function automatic logic mine_of(input logic [31:0] a, input logic b4,
                                   input logic [1:0] ib, input logic [1:0] unit);
    logic [31:0] s;
    logic [1:0]  m;
    s = blk_shift(a, b4);
    m = (ib == 2'h2) ? 2'h3 : ((ib == 2'h1) ? 2'h1 : 2'h0);
    return ((s[1:0] ^ unit) & m) == 2'h0;
  endfunction

  assign ibits   = (ilv_ff == wtc_pkg::ILV_ONE) ? 2'h0 :
                   ((ilv_ff == wtc_pkg::ILV_TWO) ? 2'h1 : 2'h2);
  assign rq_set  = set_of(req_i.addr, blk4_ff, ibits);
  assign rq_line = line_of(req_i.addr, blk4_ff);
  assign rq_tag  = req_i.addr[31:wtc_pkg::TAG_LSB];
  assign rq_mine = mine_of(req_i.addr, blk4_ff, ibits, unit_ff);
  assign sn_set  = set_of(snoop_i.addr, blk4_ff, ibits);
  assign sn_line = line_of(snoop_i.addr, blk4_ff);
  assign sn_tag  = snoop_i.addr[31:wtc_pkg::TAG_LSB];
  assign p_set   = set_of(p_addr_ff, blk4_ff, ibits);
  assign p_line  = line_of(p_addr_ff, blk4_ff);

  // Parallel compare per way
  for (genvar w = 0; w < wtc_pkg::WAYS; w++) begin : g_way
    assign rq_tagm[w] = tv_ff[w][rq_set] &&
                        (((tag_ff[w][rq_set] ^ rq_tag) & tmask_ff) == '0);
    assign rq_hitv[w] = rq_tagm[w] & lv_ff[w][rq_set][rq_line];
    assign sn_tagm[w] = tv_ff[w][sn_set] &&
                        (((tag_ff[w][sn_set] ^ sn_tag) & tmask_ff) == '0);
    assign sn_hitv[w] = sn_tagm[w] & lv_ff[w][sn_set][sn_line];
  end

  assign rq_hit = |rq_hitv;
  assign sn_way = sn_hitv[1];
  // Own cacheable writes are write-through hits and keep their line
  assign sn_clr = snoop_i.valid && (|sn_hitv) && (!snoop_i.from_self || !snoop_i.cacheable) &&
                  mine_of(snoop_i.addr, blk4_ff, ibits, unit_ff);

  assign accept   = req_i.valid && req_ready_o;
  assign serve    = req_i.recog && rq_mine;
  // Size and access type are not inputs of the decision
  assign cach     = serve && en_ff && req_i.cacheable && !req_i.locked;
  assign fill_ok  = (state_ff == wtc_pkg::WTC_MEM) && sbrep_i.done && p_fill_ff && !sbrep_i.bad;
  assign fill_bad = (state_ff == wtc_pkg::WTC_MEM) && sbrep_i.done && p_fill_ff && sbrep_i.bad;

  // Request sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff    <= wtc_pkg::WTC_IDLE;
      req_ready_o <= 1'b0;
      resp_o      <= '0;
      sbreq_o     <= '0;
      p_addr_ff   <= '0;
      p_fill_ff   <= 1'b0;
      p_whit_ff   <= 1'b0;
      p_way_ff    <= 1'b0;
      p_tagm_ff   <= 1'b0;
    end else begin
      resp_o <= '0;
      unique case (state_ff)
        wtc_pkg::WTC_IDLE: begin
          req_ready_o <= 1'b1;
          if (accept) begin
            if (!serve) begin
              resp_o.done <= 1'b1;
            end else if (cach && !req_i.write && rq_hit) begin
              resp_o.done       <= 1'b1;
              resp_o.hit        <= 1'b1;
              resp_o.way        <= rq_hitv[1];
              resp_o.cache_read <= 1'b1;
            end else begin
              req_ready_o    <= 1'b0;
              state_ff       <= wtc_pkg::WTC_MEM;
              sbreq_o.valid  <= 1'b1;
              sbreq_o.write  <= req_i.write;
              sbreq_o.line16 <= cach && !req_i.write;
              sbreq_o.addr   <= (cach && !req_i.write) ?
                                {req_i.addr[31:wtc_pkg::LINE_LSB], 4'h0} : req_i.addr;
              p_addr_ff      <= req_i.addr;
              p_fill_ff      <= cach && !req_i.write;
              p_whit_ff      <= cach && req_i.write && rq_hit;
              p_tagm_ff      <= |rq_tagm;
              p_way_ff       <= (cach && req_i.write) ? rq_hitv[1] :
                                ((|rq_tagm) ? rq_tagm[1] : toggle_ff);
            end
          end
        end
        wtc_pkg::WTC_MEM: begin
          if (sbrep_i.done) begin
            sbreq_o.valid          <= 1'b0;
            state_ff               <= wtc_pkg::WTC_IDLE;
            req_ready_o            <= 1'b1;
            resp_o.done            <= 1'b1;
            resp_o.hit             <= p_whit_ff;
            resp_o.way             <= p_way_ff;
            resp_o.bad_access_flag <= sbrep_i.bad;
            // Write miss leaves the data array alone
            resp_o.cache_write     <= p_whit_ff || fill_ok;
          end
        end
      endcase
    end
  end

  // Replacement toggle
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_ff) begin
      toggle_ff <= 1'b0;
    end else if (accept && cach) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  // Directory update: fill, then snoop so a racing invalidate wins
  always_ff @(posedge clk_i) begin
    if (rst_i || fill_bad) begin
      for (int w = 0; w < wtc_pkg::WAYS; w++) begin
        tv_ff[w] <= '0;
      end
    end else begin
      if (fill_ok) begin
        tv_ff[p_way_ff][p_set] <= 1'b1;
        if (p_tagm_ff) begin
          lv_ff[p_way_ff][p_set][p_line] <= 1'b1;
        end else begin
          tag_ff[p_way_ff][p_set] <= p_addr_ff[31:wtc_pkg::TAG_LSB];
          lv_ff[p_way_ff][p_set]  <= 8'h01 << p_line;
        end
      end
      if (sn_clr) begin
        lv_ff[sn_way][sn_set][sn_line] <= 1'b0;
      end
    end
  end

  // Hit and miss counters
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hits_ff <= '0;
      miss_ff <= '0;
    end else if (accept && cach) begin
      if (rq_hit) begin
        hits_ff <= hits_ff + 32'h1;
      end else begin
        miss_ff <= miss_ff + 32'h1;
      end
    end
  end

  // AHB-Lite slave, zero wait states
  assign ahb_addr_ph = hsel_i && htrans_i[1] && hready_i;

  always_comb begin
    rd_val = 32'h0;
    unique case (haddr_i[7:0])
      wtc_pkg::CTRL_OFF: begin
        rd_val[wtc_pkg::CTRL_EN_BIT]   = en_ff;
        rd_val[wtc_pkg::CTRL_BLK4_BIT] = blk4_ff;
        rd_val[wtc_pkg::CTRL_ILV_LSB+:2]  = ilv_ff;
        rd_val[wtc_pkg::CTRL_UNIT_LSB+:2] = unit_ff;
      end
      wtc_pkg::TMASK_OFF: rd_val = {12'h000, tmask_ff};
      wtc_pkg::STAT_OFF: begin
        rd_val[wtc_pkg::STAT_EN_BIT]   = en_ff;
        rd_val[wtc_pkg::STAT_TGL_BIT]  = toggle_ff;
        rd_val[wtc_pkg::STAT_BUSY_BIT] = (state_ff == wtc_pkg::WTC_MEM);
      end
      wtc_pkg::HITS_OFF: rd_val = hits_ff;
      wtc_pkg::MISS_OFF: rd_val = miss_ff;
      default: rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_pend_ff  <= 1'b0;
      aw_addr_ff  <= '0;
      hrdata_o    <= '0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      aw_pend_ff  <= ahb_addr_ph && hwrite_i;
      aw_addr_ff  <= haddr_i[7:0];
      hrdata_o    <= (ahb_addr_ph && !hwrite_i) ? rd_val : 32'h0;
    end
  end

  // Configuration writes; unsupported combos are software's concern
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff    <= wtc_pkg::CTRL_RST[wtc_pkg::CTRL_EN_BIT];
      blk4_ff  <= wtc_pkg::CTRL_RST[wtc_pkg::CTRL_BLK4_BIT];
      ilv_ff   <= wtc_pkg::CTRL_RST[wtc_pkg::CTRL_ILV_LSB+:2];
      unit_ff  <= wtc_pkg::CTRL_RST[wtc_pkg::CTRL_UNIT_LSB+:2];
      tmask_ff <= wtc_pkg::TMASK_RST;
    end else if (aw_pend_ff) begin
      if (aw_addr_ff == wtc_pkg::CTRL_OFF) begin
        en_ff   <= hwdata_i[wtc_pkg::CTRL_EN_BIT];
        blk4_ff <= hwdata_i[wtc_pkg::CTRL_BLK4_BIT];
        ilv_ff  <= hwdata_i[wtc_pkg::CTRL_ILV_LSB+:2];
        unit_ff <= hwdata_i[wtc_pkg::CTRL_UNIT_LSB+:2];
      end
      if (aw_addr_ff == wtc_pkg::TMASK_OFF) begin
        tmask_ff <= hwdata_i[wtc_pkg::TAG_W-1:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic                      chk_sn_ff;
  logic                      chk_way_ff;
  logic [wtc_pkg::SET_W-1:0] chk_set_ff;
  logic [2:0]                chk_line_ff;

  always_ff @(posedge clk_i) begin
    chk_sn_ff   <= sn_clr && !rst_i;
    chk_way_ff  <= sn_way;
    chk_set_ff  <= sn_set;
    chk_line_ff <= sn_line;
  end

  read_hit_a: assert property (accept && cach && !req_i.write && rq_hit |=>
    resp_o.done && resp_o.hit && resp_o.cache_read && req_ready_o)
    else $error("read hit not answered next cycle");

  read_miss_a: assert property (accept && cach && !req_i.write && !rq_hit |=>
    sbreq_o.valid && sbreq_o.line16 && sbreq_o.addr[3:0] == 4'h0 && !req_ready_o)
    else $error("read miss did not issue aligned line request");

  write_miss_a: assert property (accept && cach && req_i.write && !rq_hit |=>
    (sbreq_o.valid && sbreq_o.write && !sbreq_o.line16) ##0
    (!resp_o.cache_write throughout (sbreq_o.valid [*1] ##1 1'b1)))
    else $error("write miss touched the cache");

  write_hit_a: assert property (state_ff == wtc_pkg::WTC_MEM && p_whit_ff &&
    sbrep_i.done |=> resp_o.done && resp_o.cache_write && resp_o.hit)
    else $error("write hit not written through");

  toggle_flip_a: assert property (en_ff && accept && cach |=>
    toggle_ff != $past(toggle_ff) || !en_ff)
    else $error("toggle did not flip on cacheable access");

  toggle_clr_a: assert property (!en_ff |=> toggle_ff == 1'b0)
    else $error("toggle not held at way 0 while disabled");

  bad_fill_a: assert property (fill_bad |=>
    tv_ff[0] == '0 && tv_ff[1] == '0 && resp_o.bad_access_flag)
    else $error("bad fill did not invalidate directory");

  snoop_clr_a: assert property (chk_sn_ff |->
    !lv_ff[chk_way_ff][chk_set_ff][chk_line_ff])
    else $error("snoop hit left line valid");

  reset_tv_a: assert property ($fell(rst_i) |-> tv_ff[0] == '0 && tv_ff[1] == '0)
    else $error("tag valid bits survive reset");

endmodule

// ### test/wtc_sys_mem.sv
// System memory responder answering the directory's system-bus requests
`timescale 1ns/10ps
module wtc_sys_mem (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire wtc_pkg::wtc_sbreq_t sbreq_i,
  input  wire logic [3:0]          dly_i,
  input  wire logic                bad_i,
  output wtc_pkg::wtc_sbrep_t      sbrep_o
);
  logic [3:0] wait_ff;

  // One reply per request, whole line in one beat; bad flag only means something with done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_ff <= 4'h0;
      sbrep_o <= '0;
    end else begin
      sbrep_o.done <= 1'b0;
      sbrep_o.bad  <= ~sbrep_o.bad;
      if (sbreq_i.valid && !sbrep_o.done) begin
        if (wait_ff == dly_i) begin
          sbrep_o.done <= 1'b1;
          sbrep_o.bad  <= bad_i;
          wait_ff      <= 4'h0;
        end else begin
          wait_ff <= wait_ff + 4'h1;
        end
      end else begin
        wait_ff <= 4'h0;
      end
    end
  end
endmodule

// ### test/tb_write_through_cache_directory.sv
// Directed testbench for the write-through cache directory
`timescale 1ns/10ps
module tb_write_through_cache_directory;
  localparam logic [2:0] RD = 3'b010;
  localparam logic [2:0] WR = 3'b110;
  localparam logic [2:0] NC = 3'b000;
  localparam logic [2:0] LK = 3'b011;
  localparam logic [4:0] MISS = 5'b01110;
  localparam logic [4:0] MISS1 = 5'b01111;
  localparam logic [4:0] HIT0 = 5'b10000;
  localparam logic [4:0] HIT1 = 5'b10001;
  localparam logic [4:0] FWD  = 5'b01000;
  localparam logic [31:0] A = 32'h0000_1234;
  localparam logic [31:0] B = 32'h0010_1234;
  localparam logic [31:0] C = 32'h0020_0040;
  localparam logic [31:0] E = 32'h0040_0400;

  logic                clk_i;
  logic                rst_q;
  wtc_pkg::wtc_req_t   req_q;
  logic                req_ready_o;
  wtc_pkg::wtc_resp_t  resp_o;
  wtc_pkg::wtc_sbreq_t sbreq_o;
  wtc_pkg::wtc_sbrep_t sbrep;
  wtc_pkg::wtc_snoop_t snoop_q;
  logic                hsel_q;
  logic [31:0]         haddr_q;
  logic [1:0]          htrans_q;
  logic                hwrite_q;
  logic [31:0]         hwdata_q;
  logic [2:0]          hsize_q;
  logic [31:0]         hrdata_o;
  logic                hreadyout_o;
  logic                hresp_o;
  logic                bad_q;
  logic [3:0]          dly_q;
  logic [31:0]         junk;
  int                  fails;
  int                  cmp_count;
  int                  cyc;

  wtc_cache_dir dut (
    .clk_i(clk_i), .rst_i(rst_q), .req_i(req_q), .req_ready_o(req_ready_o),
    .resp_o(resp_o), .sbreq_o(sbreq_o), .sbrep_i(sbrep), .snoop_i(snoop_q),
    .hsel_i(hsel_q), .haddr_i(haddr_q), .htrans_i(htrans_q), .hwrite_i(hwrite_q),
    .hsize_i(hsize_q), .hwdata_i(hwdata_q), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o)
  );

  wtc_sys_mem u_mem (
    .clk_i(clk_i), .rst_i(rst_q), .sbreq_i(sbreq_o), .dly_i(dly_q), .bad_i(bad_q),
    .sbrep_o(sbrep)
  );

  always #4 clk_i = ~clk_i;

  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Single AHB-Lite transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    hsel_q   <= 1'b1;
    htrans_q <= 2'h2;
    haddr_q  <= {24'h0, a};
    hwrite_q <= w;
    hsize_q  <= 3'h2;
    do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 20);
    hsel_q   <= 1'b0;
    htrans_q <= 2'h0;
    hwdata_q <= wd;
    n = 0;
    do begin @(posedge clk_i); n++; end while (hreadyout_o !== 1'b1 && n < 20);
    rd = hrdata_o;
    chk("hresp", 32'h0, {31'h0, hresp_o});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk($sformatf("reg %h", a), ex, v);
  endtask

  // f: write, cacheable, locked; e: hit, bus, line16, cache_write, way
  task automatic cpu(input logic [31:0] a, input logic [2:0] f, input logic [4:0] e);
    int n;
    logic bus;
    logic l16;
    logic [31:0] sa;
    logic sw;
    wtc_pkg::wtc_resp_t r;
    n = 0;
    bus = 1'b0;
    l16 = 1'b0;
    sa = 32'h0;
    sw = 1'b0;
    @(posedge clk_i);
    #1;
    while (req_ready_o !== 1'b1 && n < 50) begin @(posedge clk_i); #1; n++; end
    @(posedge clk_i);
    req_q <= '{valid:1'b1, addr:a, write:f[2], cacheable:f[1], recog:1'b1, locked:f[0]};
    @(posedge clk_i);
    req_q.valid <= 1'b0;
    for (n = 0; n < 60; n++) begin
      #1;
      if (sbreq_o.valid === 1'b1) begin
        bus = 1'b1;
        l16 = sbreq_o.line16;
        sa = sbreq_o.addr;
        sw = sbreq_o.write;
      end
      if (resp_o.done === 1'b1) break;
      @(posedge clk_i);
    end
    r = resp_o;
    chk("done", 32'h1, {31'h0, r.done});
    chk("hit", {31'h0, e[4]}, {31'h0, r.hit});
    chk("bus", {31'h0, e[3]}, {31'h0, bus});
    chk("line16", {31'h0, e[2]}, {31'h0, l16});
    if (bus) chk("sb addr", e[2] ? {a[31:4], 4'h0} : a, sa);
    if (bus) chk("sb write", {31'h0, f[2]}, {31'h0, sw});
    chk("cache_write", {31'h0, e[1]}, {31'h0, r.cache_write});
    chk("cache_read", {31'h0, e[4] & ~f[2]}, {31'h0, r.cache_read});
    chk("bad", {31'h0, bad_q & e[3]}, {31'h0, r.bad_access_flag});
    if (e[4] | e[1]) chk("way", {31'h0, e[0]}, {31'h0, r.way});
  endtask

  task automatic snoop(input logic [31:0] a, input logic s, input logic c);
    @(posedge clk_i);
    snoop_q <= '{valid:1'b1, addr:a, from_self:s, cacheable:c};
    @(posedge clk_i);
    snoop_q.valid <= 1'b0;
  endtask

  task automatic do_reset();
    rst_q <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_q <= 1'b0;
  endtask

  initial begin
    clk_i = 1'b0;
    rst_q = 1'b1;
    req_q = '0;
    snoop_q = '0;
    hsel_q = 1'b0;
    haddr_q = 32'h0;
    htrans_q = 2'h0;
    hwrite_q = 1'b0;
    hsize_q = 3'h0;
    hwdata_q = 32'h0;
    bad_q = 1'b0;
    dly_q = 4'h0;
    fails = 0;
    cmp_count = 0;
    cyc = 0;
    do_reset();
    rchk(wtc_pkg::CTRL_OFF, wtc_pkg::CTRL_RST);
    rchk(wtc_pkg::TMASK_OFF, {12'h0, wtc_pkg::TMASK_RST});
    rchk(wtc_pkg::STAT_OFF, 32'h0);
    rchk(8'h40, 32'h0);
    ahb(1'b1, wtc_pkg::CTRL_OFF, 32'h1, junk);
    rchk(wtc_pkg::STAT_OFF, 32'h1);
    cpu(A, RD, MISS);
    cpu(A, RD, HIT0);
    cpu(A + 32'h10, RD, MISS);
    dly_q <= 4'h5;
    cpu(B, RD, MISS1);
    cpu(B, RD, HIT1);
    cpu(A, RD, HIT0);
    cpu(A, WR, 5'b11010);
    cpu(C, WR, FWD);
    cpu(C, RD, MISS);
    snoop(B + 32'h5, 1'b0, 1'b1);
    cpu(B, RD, MISS1);
    snoop(A, 1'b1, 1'b1);
    cpu(A, RD, HIT0);
    snoop(A, 1'b1, 1'b0);
    cpu(A, RD, MISS);
    dly_q <= 4'h0;
    cpu(A, NC, FWD);
    cpu(A, LK, FWD);
    bad_q <= 1'b1;
    cpu(32'h0030_0800, RD, 5'b01100);
    bad_q <= 1'b0;
    cpu(A, RD, MISS1);
    cpu(A, RD, HIT1);
    rchk(wtc_pkg::STAT_OFF, 32'h3);
    ahb(1'b1, wtc_pkg::CTRL_OFF, 32'h0, junk);
    rchk(wtc_pkg::STAT_OFF, 32'h0);
    ahb(1'b1, wtc_pkg::CTRL_OFF, 32'h1, junk);
    rchk(wtc_pkg::STAT_OFF, 32'h1);
    cpu(E, RD, MISS);
    rchk(wtc_pkg::STAT_OFF, 32'h3);
    rchk(wtc_pkg::HITS_OFF, 32'h6);
    rchk(wtc_pkg::MISS_OFF, 32'ha);
    @(posedge clk_i);
    do_reset();
    ahb(1'b1, wtc_pkg::CTRL_OFF, 32'h1, junk);
    cpu(E, RD, MISS);
    ahb(1'b1, wtc_pkg::CTRL_OFF, 32'h17, junk);
    rchk(wtc_pkg::CTRL_OFF, 32'h17);
    cpu(32'h0000_1200, RD, 5'b00000);
    cpu(32'h0000_1240, RD, MISS1);
    ahb(1'b1, wtc_pkg::TMASK_OFF, 32'h000f_fffd, junk);
    rchk(wtc_pkg::TMASK_OFF, 32'h000f_fffd);
    cpu(32'h0000_3240, RD, HIT1);
    give_verdict();
  end
endmodule
